// ===== rtl/btx_pkg.sv
// Register map, control bits and codes of the bulk transmit path
`default_nettype none
package btx_pkg;
  // Register byte addresses on the host port
  localparam logic [8:0] A_CACK  = 9'h004;
  localparam logic [8:0] A_BACK  = 9'h008;
  localparam logic [8:0] A_CTRL  = 9'h0ec;
  localparam logic [8:0] A_ASZ   = 9'h104;
  localparam logic [8:0] A_AFREE = 9'h108;
  localparam logic [8:0] A_AFC   = 9'h10c;
  localparam logic [8:0] A_ALS   = 9'h110;
  localparam logic [8:0] A_ISZ   = 9'h12c;
  localparam logic [8:0] A_IFREE = 9'h130;
  localparam logic [8:0] A_IFC   = 9'h134;
  localparam logic [8:0] A_ILS   = 9'h138;
  localparam logic [8:0] A_RTRY  = 9'h14c;
  localparam logic [8:0] A_AH0   = 9'h1b0;
  localparam logic [8:0] A_AH1   = 9'h1b4;
  localparam logic [8:0] A_AH2   = 9'h1b8;
  localparam logic [8:0] A_AH3   = 9'h1bc;
  localparam logic [8:0] A_IH    = 9'h1c0;
  // Control bits in application_data_control; iso bits sit CH_STRIDE higher
  localparam int B_ON      = 0;
  localparam int B_SRC     = 1;
  localparam int B_HINS    = 2;
  localparam int B_FLUSH   = 3;
  localparam int CH_STRIDE = 8;
  // Ack status layout
  localparam int ACK_ERR_BIT = 23;
  localparam int ACK_CODE_LO = 24;
  // Retry configuration fields, nine bits each
  localparam int RC_NUM_LO = 0;
  localparam int RC_INT_LO = 16;
  // Header fields
  localparam int HDR_TCODE_LO = 4;
  localparam int HDR_LEN_LO   = 16;
  localparam logic [3:0] TCODE_WQ   = 4'h0;
  localparam logic [3:0] TCODE_WB   = 4'h1;
  localparam logic [3:0] ACK_BUSY_X = 4'h4;
  localparam logic [1:0] HDR_LAST   = 2'h3;
  // Byte port and host lanes
  localparam logic [2:0]  FMT_LAST   = 3'h1;
  localparam logic [1:0]  LANE0      = 2'h0;
  localparam logic [1:0]  LANE_TOP   = 2'h3;
  localparam int          BYTE_W     = 8;
  localparam logic [15:0] QUAD_BYTES = 16'h0004;
  localparam int          SIZE_UNIT  = 4;
endpackage : btx_pkg
`default_nettype wire

// ===== rtl/bulk_async_iso_tx_path.sv
// Bulk asynchronous and isochronous transmit path with host register port
//
// Operation
// - async FIFO capacity from size register, four-quadlet units
// - async free quadlet count readable
// - async header from four words, tcode 0/1
// - async source and header selection bits
// - bulk last-byte marker starts transmission
// - host last-and-send write starts transmission
// - pad only the final quadlet
// - async flush empties the FIFO
// - bounded automatic retry, control FIFO excluded
// - single-phase retry only
// - byte count reaching length starts transmission under header insertion
// - bulk ack code and error stored
// - control FIFO ack code and error stored
// - iso FIFO size and free count
// - iso header from one register
// - iso source and header selection bits
// - iso bulk last byte sends, padded
// - mode bits live in application control
// - byte-wide host port stacks 32-bit words
`timescale 1ns/100ps
`default_nettype none
module bulk_async_iso_tx_path #(
  parameter int DEPTH = 64
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [8:0]  host_addr_in,
  input  wire logic [7:0]  host_wdata_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  output logic      [7:0]  host_rdata_out,
  input  wire logic [7:0]  bulk_data_in,
  input  wire logic [2:0]  bulk_fmt_in,
  input  wire logic        bulk_valid_in,
  input  wire logic        bulk_iso_in,
  output logic             bulk_ready_out,
  output logic      [31:0] tx_data_out,
  output logic             tx_valid_out,
  output logic             tx_last_out,
  output logic             tx_iso_out,
  input  wire logic        tx_ready_in,
  input  wire logic        ack_valid_in,
  input  wire logic        ack_ctrl_in,
  input  wire logic        ack_err_in,
  input  wire logic [3:0]  ack_code_in,
  input  wire logic        cycle_start_in
);
  localparam int AW = $clog2(DEPTH);

  typedef enum logic [2:0] {IDLE, HDR, DATA, DONE, ACK, RWAIT} st_type;

  typedef struct packed {
    logic [31:0]                  ctl, rcfg, back, cack, ih, rsnap;
    logic [1:0][31:0]             sz;
    logic [3:0][31:0]             ah;
    logic [23:0]                  wbuf;
    logic [7:0]                   rdata;
    logic [1:0][DEPTH-1:0][31:0]  mem;
    logic [1:0][AW-1:0]           wp, rp;
    logic [1:0][AW:0]             cnt, acc, plen;
    logic [1:0][23:0]             pack;
    logic [1:0][1:0]              pn;
    logic [1:0][15:0]             pby;
    logic [1:0]                   pend;
    st_type                       st;
    logic                         ch;
    logic [1:0]                   hidx;
    logic [AW-1:0]                sp;
    logic [AW:0]                  sent;
    logic [8:0]                   tries, cyc;
    logic                         brdy, txv, txl, txi;
    logic [31:0]                  txd;
  } state_type;

  state_type        state_r;
  state_type        state_nxt;
  logic [8:0]       wa;
  logic [31:0]      wd;
  logic             we;
  logic             adv;
  logic             tc_ok;
  logic [1:0]       on, src, hins, fl;
  logic [1:0][15:0] dlen;
  logic [1:0][31:0] capw, freew;

  // Host byte stacking: lanes 0..2 are held, lane 3 commits the word
  assign wa  = {host_addr_in[8:2], 2'b00};
  assign wd  = {host_wdata_in, state_r.wbuf};
  assign we  = host_wr_in && (host_addr_in[1:0] == btx_pkg::LANE_TOP);
  assign adv = !state_r.txv || tx_ready_in;
  assign tc_ok = (state_r.ah[0][btx_pkg::HDR_TCODE_LO +: 4] == btx_pkg::TCODE_WQ) ||
                 (state_r.ah[0][btx_pkg::HDR_TCODE_LO +: 4] == btx_pkg::TCODE_WB);
  // Quadlet write carries four bytes and no length field
  assign dlen[0] = (state_r.ah[0][btx_pkg::HDR_TCODE_LO +: 4] == btx_pkg::TCODE_WQ) ?
                   btx_pkg::QUAD_BYTES : state_r.ah[3][btx_pkg::HDR_LEN_LO +: 16];
  assign dlen[1] = state_r.ih[btx_pkg::HDR_LEN_LO +: 16];

  // Per-channel mode decode, capacity and free space
  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam int OFS = btx_pkg::CH_STRIDE * c;
    assign on[c]   = state_r.ctl[btx_pkg::B_ON + OFS];
    assign src[c]  = state_r.ctl[btx_pkg::B_SRC + OFS];
    assign hins[c] = state_r.ctl[btx_pkg::B_HINS + OFS];
    assign fl[c]   = we && (wa == btx_pkg::A_CTRL) && wd[btx_pkg::B_FLUSH + OFS];
    // Sizes beyond the physical array clamp to it
    assign capw[c] = (state_r.sz[c] > 32'(DEPTH / btx_pkg::SIZE_UNIT)) ? 32'(DEPTH) :
                     32'(state_r.sz[c] * btx_pkg::SIZE_UNIT);
    assign freew[c] = (capw[c] > 32'(state_r.cnt[c])) ?
                      capw[c] - 32'(state_r.cnt[c]) : 32'h0;
  end

  // Next-state logic: registers, FIFO fill, transmitter
  always_comb begin
    logic [31:0] qw;
    logic [31:0] rw;
    logic [31:0] ackw;
    logic        push;
    logic        last;
    logic        go;
    logic        gc;
    logic [1:0]  rel;
    state_nxt = state_r;
    qw = '0;
    rw = '0;
    push = 1'b0;
    last = 1'b0;
    go = 1'b0;
    gc = 1'b0;
    rel = '0;
    ackw = '0;
    ackw[btx_pkg::ACK_ERR_BIT] = ack_err_in;
    ackw[btx_pkg::ACK_CODE_LO +: 4] = ack_code_in;
    if (host_wr_in && !we) begin
      state_nxt.wbuf[btx_pkg::BYTE_W * host_addr_in[1:0] +: btx_pkg::BYTE_W] = host_wdata_in;
    end
    // Read mux; FIFO data ports are write-only and read zero
    case (wa)
      btx_pkg::A_CACK:  rw = state_r.cack;
      btx_pkg::A_BACK:  rw = state_r.back;
      btx_pkg::A_CTRL:  rw = state_r.ctl;
      btx_pkg::A_ASZ:   rw = state_r.sz[0];
      btx_pkg::A_AFREE: rw = freew[0];
      btx_pkg::A_ISZ:   rw = state_r.sz[1];
      btx_pkg::A_IFREE: rw = freew[1];
      btx_pkg::A_RTRY:  rw = state_r.rcfg;
      btx_pkg::A_AH0:   rw = state_r.ah[0];
      btx_pkg::A_AH1:   rw = state_r.ah[1];
      btx_pkg::A_AH2:   rw = state_r.ah[2];
      btx_pkg::A_AH3:   rw = state_r.ah[3];
      btx_pkg::A_IH:    rw = state_r.ih;
      default:          rw = '0;
    endcase
    // Lane 0 snapshots the word so later lanes read a coherent value
    if (host_rd_in) begin
      if (host_addr_in[1:0] == btx_pkg::LANE0) begin
        state_nxt.rsnap = rw;
        state_nxt.rdata = rw[btx_pkg::BYTE_W-1:0];
      end else begin
        state_nxt.rdata = state_r.rsnap[btx_pkg::BYTE_W * host_addr_in[1:0] +: btx_pkg::BYTE_W];
      end
    end
    // Register writes; flush bits never stay set
    if (we) begin
      case (wa)
        btx_pkg::A_CTRL: begin
          state_nxt.ctl = wd;
          state_nxt.ctl[btx_pkg::B_FLUSH] = 1'b0;
          state_nxt.ctl[btx_pkg::B_FLUSH + btx_pkg::CH_STRIDE] = 1'b0;
        end
        btx_pkg::A_ASZ:  state_nxt.sz[0] = wd;
        btx_pkg::A_ISZ:  state_nxt.sz[1] = wd;
        btx_pkg::A_RTRY: state_nxt.rcfg = wd;
        btx_pkg::A_AH0:  state_nxt.ah[0] = wd;
        btx_pkg::A_AH1:  state_nxt.ah[1] = wd;
        btx_pkg::A_AH2:  state_nxt.ah[2] = wd;
        btx_pkg::A_AH3:  state_nxt.ah[3] = wd;
        btx_pkg::A_IH:   state_nxt.ih = wd;
        default: ;
      endcase
    end
    if (ack_valid_in && ack_ctrl_in) begin
      state_nxt.cack = ackw;
    end
    // Transmitter; async has priority when both FIFOs hold a packet
    unique case (state_r.st)
      IDLE: begin
        if (state_r.pend[0] && on[0]) begin
          // Unsupported tcode under insertion is dropped unsent
          if (hins[0] && !tc_ok) rel[0] = 1'b1;
          else go = 1'b1;
        end else if (state_r.pend[1] && on[1]) begin
          go = 1'b1;
          gc = 1'b1;
        end
        if (go) begin
          state_nxt.ch = gc;
          state_nxt.sp = state_r.rp[gc];
          state_nxt.sent = '0;
          state_nxt.hidx = '0;
          state_nxt.tries = '0;
          state_nxt.cyc = '0;
          state_nxt.st = hins[gc] ? HDR : DATA;
        end
      end
      HDR: if (adv) begin
        state_nxt.txv = 1'b1;
        state_nxt.txl = 1'b0;
        state_nxt.txi = state_r.ch;
        state_nxt.txd = state_r.ch ? state_r.ih : state_r.ah[state_r.hidx];
        state_nxt.hidx = state_r.hidx + 2'h1;
        if (state_r.ch || state_r.hidx == btx_pkg::HDR_LAST) state_nxt.st = DATA;
      end
      DATA: if (adv) begin
        state_nxt.txv = 1'b1;
        state_nxt.txi = state_r.ch;
        state_nxt.txd = state_r.mem[state_r.ch][state_r.sp];
        state_nxt.txl = (state_r.sent + 1'b1) == state_r.plen[state_r.ch];
        state_nxt.sp = state_r.sp + 1'b1;
        state_nxt.sent = state_r.sent + 1'b1;
        if (state_nxt.txl) state_nxt.st = DONE;
      end
      DONE: if (adv) begin
        state_nxt.txv = 1'b0;
        state_nxt.txl = 1'b0;
        if (state_r.ch) begin
          rel[1] = 1'b1;
          state_nxt.st = IDLE;
        end else begin
          state_nxt.st = ACK;
        end
      end
      ACK: begin
        if (cycle_start_in) state_nxt.cyc = state_r.cyc + 1'b1;
        if (ack_valid_in && !ack_ctrl_in) begin
          state_nxt.back = ackw;
          // Only busy_X is retried; busy_A/B would need dual phase
          if (ack_code_in == btx_pkg::ACK_BUSY_X &&
              state_r.tries < state_r.rcfg[btx_pkg::RC_NUM_LO +: 9] &&
              state_r.cyc < state_r.rcfg[btx_pkg::RC_INT_LO +: 9]) begin
            state_nxt.tries = state_r.tries + 1'b1;
            state_nxt.st = RWAIT;
          end else begin
            rel[0] = 1'b1;
            state_nxt.st = IDLE;
          end
        end
      end
      RWAIT: if (cycle_start_in) begin
        // Resend from the packet start on the next bus cycle
        state_nxt.cyc = state_r.cyc + 1'b1;
        state_nxt.sp = state_r.rp[0];
        state_nxt.sent = '0;
        state_nxt.hidx = '0;
        state_nxt.st = hins[0] ? HDR : DATA;
      end
    endcase
    // FIFO fill per channel
    for (int c = 0; c < 2; c++) begin
      push = 1'b0;
      last = 1'b0;
      qw = '0;
      if (src[c] && on[c] && bulk_valid_in && state_r.brdy && bulk_iso_in == 1'(c)) begin
        last = (bulk_fmt_in == btx_pkg::FMT_LAST) ||
               (hins[c] && state_r.pby[c] + 16'h1 == dlen[c]);
        // Zero fill below the last byte only in the final quadlet
        qw = {state_r.pack[c], bulk_data_in} <<
             (btx_pkg::BYTE_W * (btx_pkg::LANE_TOP - state_r.pn[c]));
        push = last || state_r.pn[c] == btx_pkg::LANE_TOP;
        state_nxt.pack[c] = {state_r.pack[c][15:0], bulk_data_in};
        state_nxt.pn[c] = state_r.pn[c] + 2'h1;
        state_nxt.pby[c] = state_r.pby[c] + 16'h1;
      end else if (!src[c] && on[c] && we && !state_r.pend[c] &&
                   32'(state_r.cnt[c]) < capw[c] &&
                   (wa == (c == 0 ? btx_pkg::A_AFC : btx_pkg::A_IFC) ||
                    wa == (c == 0 ? btx_pkg::A_ALS : btx_pkg::A_ILS))) begin
        qw = wd;
        push = 1'b1;
        last = wa == (c == 0 ? btx_pkg::A_ALS : btx_pkg::A_ILS) ||
               (hins[c] && state_r.pby[c] + btx_pkg::QUAD_BYTES == dlen[c]);
        state_nxt.pby[c] = state_r.pby[c] + btx_pkg::QUAD_BYTES;
      end
      if (push) begin
        state_nxt.mem[c][state_r.wp[c]] = qw;
        state_nxt.wp[c] = state_r.wp[c] + 1'b1;
        state_nxt.acc[c] = state_r.acc[c] + 1'b1;
      end
      if (last) begin
        state_nxt.pend[c] = 1'b1;
        state_nxt.plen[c] = state_r.acc[c] + 1'b1;
        state_nxt.acc[c] = '0;
        state_nxt.pby[c] = '0;
        state_nxt.pn[c] = '0;
      end
      state_nxt.cnt[c] = state_r.cnt[c] + {{AW{1'b0}}, push} -
                         (rel[c] ? state_r.plen[c] : '0);
      if (rel[c]) begin
        state_nxt.rp[c] = state_r.rp[c] + state_r.plen[c][AW-1:0];
        state_nxt.pend[c] = 1'b0;
      end
      // Flush wins over everything on its channel
      if (fl[c]) begin
        state_nxt.cnt[c] = '0;
        state_nxt.wp[c] = '0;
        state_nxt.rp[c] = '0;
        state_nxt.acc[c] = '0;
        state_nxt.pn[c] = '0;
        state_nxt.pby[c] = '0;
        state_nxt.pend[c] = 1'b0;
        // Also catches a start in this very cycle, else stale words would go out
        if (state_nxt.st != IDLE && state_nxt.ch == 1'(c)) begin
          state_nxt.st = IDLE;
          state_nxt.txv = 1'b0;
          state_nxt.txl = 1'b0;
        end
      end
    end
    // One word of slack covers the registered ready
    state_nxt.brdy = on[bulk_iso_in] && src[bulk_iso_in] && !state_nxt.pend[bulk_iso_in] &&
                     (32'(state_nxt.cnt[bulk_iso_in]) + 32'h1 < capw[bulk_iso_in]);
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) state_r <= '0;
    else state_r <= state_nxt;
  end

  assign host_rdata_out = state_r.rdata;
  assign bulk_ready_out = state_r.brdy;
  assign tx_data_out    = state_r.txd;
  assign tx_valid_out   = state_r.txv;
  assign tx_last_out    = state_r.txl;
  assign tx_iso_out     = state_r.txi;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_hdr_go;
    state_r.st == IDLE && state_r.pend[0] && on[0] && hins[0] && tc_ok;
  endsequence
  sequence s_iso_end;
    state_r.st == DONE && state_r.ch && adv;
  endsequence

  a_flush_clears: assert property (fl[0] |=> state_r.cnt[0] == '0 && !state_r.pend[0])
    else $error("async flush left data");
  a_free_read: assert property (host_rd_in && wa == btx_pkg::A_AFREE &&
      host_addr_in[1:0] == btx_pkg::LANE0 |=> host_rdata_out == $past(freew[0][7:0]))
    else $error("free count read wrong");
  a_off_no_start: assert property (state_r.st == IDLE && on == 2'b00 |=>
      state_r.st == IDLE)
    else $error("transmit started while disabled");
  a_hdr_first: assert property (s_hdr_go ##1 (state_r.st == HDR && adv) |=>
      tx_valid_out && tx_data_out == $past(state_r.ah[0], 2))
    else $error("inserted header not first");
  a_last_send: assert property (we && wa == btx_pkg::A_ALS && on[0] && !src[0] &&
      !state_r.pend[0] && 32'(state_r.cnt[0]) < capw[0] && !fl[0] |=> state_r.pend[0])
    else $error("last-and-send did not arm packet");
  a_bulk_ack: assert property (state_r.st == ACK && ack_valid_in && !ack_ctrl_in |=>
      state_r.back[27:24] == $past(ack_code_in) && state_r.back[23] == $past(ack_err_in))
    else $error("bulk ack not stored");
  a_ctrl_ack: assert property (ack_valid_in && ack_ctrl_in |=>
      state_r.cack[27:24] == $past(ack_code_in) && state_r.cack[23] == $past(ack_err_in))
    else $error("control ack not stored");
  a_retry_bound: assert property (state_r.st == RWAIT |->
      state_r.tries <= state_r.rcfg[btx_pkg::RC_NUM_LO +: 9])
    else $error("retry count exceeded");
  a_iso_release: assert property (s_iso_end ##0 !fl[1] |=>
      state_r.st == IDLE && !tx_valid_out && !state_r.pend[1])
    else $error("iso packet not released");
endmodule : bulk_async_iso_tx_path
`default_nettype wire

// ===== verification/link_tx_model.sv
// Link transmitter and acknowledge source facing the transmit path
`timescale 1ns/100ps
`default_nettype none
module link_tx_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [31:0] tx_data_in,
  input  wire logic        tx_valid_in,
  input  wire logic        tx_last_in,
  input  wire logic        tx_iso_in,
  input  wire logic        slow_in,
  input  wire logic        ctrl_req_in,
  input  wire logic        ack_err_cmd_in,
  input  wire logic [3:0]  ack_code_cmd_in,
  output logic             tx_ready_out,
  output logic             ack_valid_out,
  output logic             ack_ctrl_out,
  output logic             ack_err_out,
  output logic [3:0]       ack_code_out
);
  logic [33:0] got_q[$];
  int          owed = 0;
  int          sent = 0;
  int          dly  = 0;
  logic [3:0]  pat  = 4'h0;

  initial begin
    tx_ready_out  = 1'b0;
    ack_valid_out = 1'b0;
    ack_ctrl_out  = 1'b0;
    ack_err_out   = 1'b0;
    ack_code_out  = 4'h0;
  end

  // Capture accepted quadlets; every async packet end owes one ack
  always @(posedge clk_in) begin
    if (!rst_in && tx_valid_in && tx_ready_out) begin
      got_q.push_back({tx_iso_in, tx_last_in, tx_data_in});
      if (tx_last_in && !tx_iso_in) owed++;
    end
  end

  // Stall pattern and ack pulses; idle ack lines wander so stale values never match
  always @(negedge clk_in) begin
    pat          <= pat + 4'h1;
    tx_ready_out <= !slow_in || pat[0];
    if (ctrl_req_in || (owed != sent && dly >= 3)) begin
      ack_valid_out <= 1'b1;
      ack_ctrl_out  <= ctrl_req_in;
      ack_err_out   <= ack_err_cmd_in;
      ack_code_out  <= ack_code_cmd_in;
    end else begin
      ack_valid_out <= 1'b0;
      ack_ctrl_out  <= pat[1];
      ack_err_out   <= pat[2];
      ack_code_out  <= ~pat;
    end
    // A control ack only postpones a bulk ack, never loses it
    if (!ctrl_req_in && owed != sent && dly >= 3) begin
      sent <= sent + 1;
      dly  <= 0;
    end else begin
      dly <= (owed != sent) ? dly + 1 : 0;
    end
  end
endmodule : link_tx_model
`default_nettype wire

// ===== verification/bulk_async_iso_tx_path_tb.sv
// Self-checking bench for the bulk transmit path
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module bulk_async_iso_tx_path_tb;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, bvalid = 0, biso = 0, cyc = 0;
  logic        slow = 0, creq = 0, aerr = 0, bready, tvalid, tlast, tiso, tready;
  logic        avalid, actrl, aerr_l;
  logic [3:0]  acode = 4'h0, acode_l;
  logic [8:0]  haddr = 9'h0;
  logic [7:0]  hwdata = 8'h0, bdata = 8'h0, hrdata;
  logic [2:0]  bfmt = 3'h0;
  logic [31:0] tdata, hdr[4];
  int          miscompares = 0, checks_done = 0;

  initial forever #4 clk = ~clk;

  bulk_async_iso_tx_path u_dut (.sys_clk_in(clk), .rst_in(rst), .host_addr_in(haddr),
    .host_wdata_in(hwdata), .host_wr_in(wr), .host_rd_in(rd), .host_rdata_out(hrdata),
    .bulk_data_in(bdata), .bulk_fmt_in(bfmt), .bulk_valid_in(bvalid), .bulk_iso_in(biso),
    .bulk_ready_out(bready), .tx_data_out(tdata), .tx_valid_out(tvalid), .tx_last_out(tlast),
    .tx_iso_out(tiso), .tx_ready_in(tready), .ack_valid_in(avalid), .ack_ctrl_in(actrl),
    .ack_err_in(aerr_l), .ack_code_in(acode_l), .cycle_start_in(cyc));

  link_tx_model u_link (.clk_in(clk), .rst_in(rst), .tx_data_in(tdata), .tx_valid_in(tvalid),
    .tx_last_in(tlast), .tx_iso_in(tiso), .slow_in(slow), .ctrl_req_in(creq),
    .ack_err_cmd_in(aerr), .ack_code_cmd_in(acode), .tx_ready_out(tready),
    .ack_valid_out(avalid), .ack_ctrl_out(actrl), .ack_err_out(aerr_l), .ack_code_out(acode_l));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // Byte lanes 0..3, lane 3 commits the word
  task automatic wr32(input logic [8:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      haddr  = a + 9'(i);
      hwdata = d[8*i +: 8];
      wr     = 1'b1;
    end
    @(negedge clk);
    wr = 1'b0;
  endtask : wr32

  task automatic chkreg(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      haddr = a + 9'(i);
      rd    = 1'b1;
      @(negedge clk);
      rd           = 1'b0;
      v[8*i +: 8]  = hrdata;
    end
    `CHK(v, e)
  endtask : chkreg

  // Bytes held until the edge that sees ready
  task automatic send_bytes(input int n, input logic [7:0] b0, input logic mark);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      bdata  = b0 + 8'(i);
      bfmt   = (mark && i == n - 1) ? btx_pkg::FMT_LAST : 3'h0;
      bvalid = 1'b1;
      k      = 0;
      while (!bready && k < 100) begin
        @(negedge clk);
        k++;
      end
      if (k == 100) begin
        miscompares++;
        end_of_test();
      end
    end
    @(negedge clk);
    bvalid = 1'b0;
    bdata  = ~bdata;
  endtask : send_bytes

  task automatic expw(input logic [31:0] d, input logic last, input logic iso);
    int          k = 0;
    logic [33:0] g;
    while (u_link.got_q.size() == 0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      miscompares++;
      end_of_test();
    end
    g = u_link.got_q.pop_front();
    `CHK(g, {iso, last, d})
  endtask : expw

  task automatic set_hdr(input logic [31:0] h0, input logic [15:0] len);
    hdr = '{h0, 32'h1111_2222, 32'h3333_4444, {len, 16'h0000}};
    for (int i = 0; i < 4; i++) wr32(btx_pkg::A_AH0 + 9'(4*i), hdr[i]);
  endtask : set_hdr

  task automatic exp_hdr();
    for (int i = 0; i < 4; i++) expw(hdr[i], 1'b0, 1'b0);
  endtask : exp_hdr

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chkreg(btx_pkg::A_CTRL, 32'h0);
    chkreg(btx_pkg::A_AFREE, 32'h0);
    chkreg(9'h1fc, 32'h0);
    chkreg(btx_pkg::A_AFC, 32'h0);
    wr32(btx_pkg::A_ASZ, 32'h2);
    wr32(btx_pkg::A_ISZ, 32'h1);
    chkreg(btx_pkg::A_ASZ, 32'h2);
    chkreg(btx_pkg::A_AFREE, 32'h8);
    chkreg(btx_pkg::A_IFREE, 32'h4);
    wr32(btx_pkg::A_AFC, 32'hdead_beef);
    chkreg(btx_pkg::A_AFREE, 32'h8);
    `CHK(bready, 1'b0)
    done("sizing");
    // Host formatted packet through a stalling link, error ack
    slow  = 1'b1;
    acode = 4'hd;
    aerr  = 1'b1;
    wr32(btx_pkg::A_CTRL, 32'h1);
    wr32(btx_pkg::A_AFC, 32'h0001_0010);
    chkreg(btx_pkg::A_AFREE, 32'h7);
    wr32(btx_pkg::A_ALS, 32'h1234_5678);
    expw(32'h0001_0010, 1'b0, 1'b0);
    expw(32'h1234_5678, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    chkreg(btx_pkg::A_BACK, 32'h0d80_0000);
    acode = 4'h5;
    aerr  = 1'b0;
    @(posedge clk) creq <= 1'b1;
    @(posedge clk) creq <= 1'b0;
    chkreg(btx_pkg::A_CACK, 32'h0500_0000);
    done("host formatted");
    // Host data with inserted header
    set_hdr(32'h0001_0010, 16'h0008);
    chkreg(btx_pkg::A_AH1, 32'h1111_2222);
    wr32(btx_pkg::A_CTRL, 32'h5);
    wr32(btx_pkg::A_AFC, 32'ha1a2_a3a4);
    wr32(btx_pkg::A_ALS, 32'hb1b2_b3b4);
    exp_hdr();
    expw(32'ha1a2_a3a4, 1'b0, 1'b0);
    expw(32'hb1b2_b3b4, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    // Bulk bytes, marked end, padded tail
    slow = 1'b0;
    set_hdr(32'h0001_0010, 16'h0006);
    wr32(btx_pkg::A_CTRL, 32'h7);
    // Ready is registered from the old mode bits, so it follows one cycle late
    @(negedge clk);
    `CHK(bready, 1'b1)
    send_bytes(6, 8'h10, 1'b1);
    exp_hdr();
    expw(32'h1011_1213, 1'b0, 1'b0);
    expw(32'h1415_0000, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    // Bulk bytes ended by the length count alone
    set_hdr(32'h0001_0010, 16'h0008);
    send_bytes(8, 8'h20, 1'b0);
    exp_hdr();
    expw(32'h2021_2223, 1'b0, 1'b0);
    expw(32'h2425_2627, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    // Bulk bytes carrying their own header
    wr32(btx_pkg::A_CTRL, 32'h3);
    send_bytes(8, 8'h40, 1'b1);
    expw(32'h4041_4243, 1'b0, 1'b0);
    expw(32'h4445_4647, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    // Unsupported tcode is never sent
    wr32(btx_pkg::A_CTRL, 32'h5);
    set_hdr(32'h0001_0040, 16'h0004);
    wr32(btx_pkg::A_ALS, 32'h0000_0005);
    repeat (30) @(negedge clk);
    `CHK(u_link.got_q.size(), 0)
    done("inserted header");
    // Busy ack retried only at a cycle start
    wr32(btx_pkg::A_CTRL, 32'h1);
    wr32(btx_pkg::A_RTRY, 32'h000a_0002);
    chkreg(btx_pkg::A_RTRY, 32'h000a_0002);
    acode = btx_pkg::ACK_BUSY_X;
    wr32(btx_pkg::A_ALS, 32'hc0c0_c0c0);
    expw(32'hc0c0_c0c0, 1'b1, 1'b0);
    repeat (20) @(negedge clk);
    `CHK(u_link.got_q.size(), 0)
    acode = 4'h1;
    cyc   = 1'b1;
    @(negedge clk);
    cyc = 1'b0;
    expw(32'hc0c0_c0c0, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    chkreg(btx_pkg::A_BACK, 32'h0100_0000);
    // Zero retry budget: busy ack releases the packet without a resend
    wr32(btx_pkg::A_RTRY, 32'h000a_0000);
    acode = btx_pkg::ACK_BUSY_X;
    wr32(btx_pkg::A_ALS, 32'hc1c1_c1c1);
    expw(32'hc1c1_c1c1, 1'b1, 1'b0);
    repeat (12) @(negedge clk);
    cyc = 1'b1;
    @(negedge clk);
    cyc = 1'b0;
    repeat (20) @(negedge clk);
    `CHK(u_link.got_q.size(), 0)
    chkreg(btx_pkg::A_BACK, 32'h0400_0000);
    done("retry");
    // Flush empties the FIFO and clears itself
    wr32(btx_pkg::A_AFC, 32'h0000_0001);
    chkreg(btx_pkg::A_AFREE, 32'h7);
    wr32(btx_pkg::A_CTRL, 32'h9);
    chkreg(btx_pkg::A_CTRL, 32'h1);
    chkreg(btx_pkg::A_AFREE, 32'h8);
    `CHK(u_link.got_q.size(), 0)
    done("flush");
    // Isochronous bulk with header, then host formatted
    wr32(btx_pkg::A_IH, 32'h0003_00a0);
    wr32(btx_pkg::A_CTRL, 32'h0700);
    biso = 1'b1;
    send_bytes(3, 8'h30, 1'b1);
    expw(32'h0003_00a0, 1'b0, 1'b1);
    expw(32'h3031_3200, 1'b1, 1'b1);
    biso = 1'b0;
    wr32(btx_pkg::A_CTRL, 32'h0100);
    wr32(btx_pkg::A_IFC, 32'h4444_0000);
    chkreg(btx_pkg::A_IFREE, 32'h3);
    wr32(btx_pkg::A_ILS, 32'h5555_0000);
    expw(32'h4444_0000, 1'b0, 1'b1);
    expw(32'h5555_0000, 1'b1, 1'b1);
    done("isochronous");
    end_of_test();
  end

  // Hang guard
  initial begin
    #400_000;
    miscompares++;
    end_of_test();
  end
endmodule : bulk_async_iso_tx_path_tb
`default_nettype wire
